//--- pkg/amc_pkg.sv
// Constants and types shared by the macroblock-type skip/direct conversion ends.
// Summary of operation
// RQ1: P skip: kind 1, skip set, no vectors.
// RQ2: B skip 8x8: 16h, skip, mask Fh, shape 0.
// RQ3: B skip 4x4: 16h, skip, Fh, FFh, no 8x8.
// RQ4: B direct 8x8: 16h, no skip, Fh, shape 0.
// RQ5: B direct 4x4: 16h, Fh, FFh, 8x8 transform cleared.
// RQ6: Four-pair shape 0; sixteen-pair shape FFh.
// RQ7: Packer detects P 8x8 all-reference-zero itself.
// RQ8: Slice direct/skip disables plus per-block skip disable.
// RQ9: P slice: only 16x16 list-0 becomes skip.
// RQ10: CBP is post-quantization, masked by input bits.
// RQ11: Forced P skip, pair allowed: skip, CBP zero.
// RQ12: Forced P skip, pair refused: type 0, CBP zero.
// RQ13: L0 16x16, CBP zero, MV==MVP, allowed: skip.
// RQ14: Same but pair refused: type 0, no skip.
// RQ15: Slice skip disable set: type 0, no skip.
// RQ16: B skip/direct: no vector-predictor check.
// RQ17: Skipped block carries no vectors or coefficients.
// RQ18: Skip predictor check uses reference index zero.
// RQ19: Skip predictor zero on missing/zero neighbour A or B.
// RQ20: Decision inputs: CBP fields, skip bit, direct mask.
// RQ21: Pair skip permitted held 1 outside MBAFF.
package amc_pkg;

  localparam int AMC_KIND_W = 5;
  localparam int AMC_MV_W = 16;
  localparam int AMC_REF_W = 4;
  localparam int AMC_CNT_W = 6;

  localparam logic [4:0] AMC_KIND_RESERVED = 5'h00;
  localparam logic [4:0] AMC_KIND_L0_16X16 = 5'h01;
  localparam logic [4:0] AMC_KIND_L0_L0_16X8 = 5'h04;
  localparam logic [4:0] AMC_KIND_L0_L0_8X16 = 5'h05;
  localparam logic [4:0] AMC_KIND_8X8 = 5'h16;

  localparam logic [3:0] AMC_DIRECT_ALL = 4'hF;
  localparam logic [7:0] AMC_SHAPE_4PAIR = 8'h00;
  localparam logic [7:0] AMC_SHAPE_16PAIR = 8'hFF;
  localparam logic [5:0] AMC_PAIRS_4 = 6'h04;
  localparam logic [5:0] AMC_PAIRS_16 = 6'h10;

  // Coded mb_type symbols.
  localparam logic [4:0] AMC_P_TYPE_L0_16X16 = 5'h00;
  localparam logic [4:0] AMC_P_TYPE_16X8 = 5'h01;
  localparam logic [4:0] AMC_P_TYPE_8X16 = 5'h02;
  localparam logic [4:0] AMC_P_TYPE_8X8 = 5'h03;
  localparam logic [4:0] AMC_P_TYPE_8X8_REF0 = 5'h04;
  localparam logic [4:0] AMC_B_TYPE_DIRECT = 5'h00;

  localparam logic [AMC_REF_W-1:0] AMC_SKIP_REF = 4'h0;

  typedef enum logic [1:0] {
    AMC_REQ_NORMAL,
    AMC_REQ_SKIP,
    AMC_REQ_DIRECT
  } amc_req_t;

endpackage

//--- pkg/amc_link_if.sv
// Interface carrying one macroblock descriptor from the command stream to the packer.
`timescale 1ns/10ps
interface amc_link_if
  import amc_pkg::*;
();
  logic                 mb_valid;
  logic                 slice_is_b;
  logic [4:0]           mb_kind_code;
  logic                 skip_indicator;
  logic [3:0]           direct_quadrant_mask;
  logic [7:0]           sub_partition_shape;
  logic [7:0]           sub_prediction_direction;
  logic [5:0]           vector_count;
  logic                 transform_8x8_flag;
  logic [15:0]          cbp_luma;
  logic [3:0]           cbp_cb;
  logic [3:0]           cbp_cr;
  logic                 per_block_skip_conversion_off;
  logic [15:0]          ref_idx_l0;
  logic [AMC_MV_W-1:0]  mv_x;
  logic [AMC_MV_W-1:0]  mv_y;

  modport cmd (
    output mb_valid, slice_is_b, mb_kind_code, skip_indicator, direct_quadrant_mask,
    output sub_partition_shape, sub_prediction_direction, vector_count,
    output transform_8x8_flag, cbp_luma, cbp_cb, cbp_cr, per_block_skip_conversion_off,
    output ref_idx_l0, mv_x, mv_y
  );
  modport pak (
    input mb_valid, slice_is_b, mb_kind_code, skip_indicator, direct_quadrant_mask,
    input sub_partition_shape, sub_prediction_direction, vector_count,
    input transform_8x8_flag, cbp_luma, cbp_cb, cbp_cr, per_block_skip_conversion_off,
    input ref_idx_l0, mv_x, mv_y
  );
endinterface

//--- hdl/amc_skip_pred.sv
// Predicted list-0 vector for a skipped macroblock from neighbours A, B and C.
`timescale 1ns/10ps
module amc_skip_pred
  import amc_pkg::*;
#(
  parameter int MV_W = AMC_MV_W
)(
  input  wire logic                 a_avail,
  input  wire logic                 b_avail,
  input  wire logic                 c_avail,
  input  wire logic [AMC_REF_W-1:0] a_ref,
  input  wire logic [AMC_REF_W-1:0] b_ref,
  input  wire logic [AMC_REF_W-1:0] c_ref,
  input  wire logic [2*MV_W-1:0]    a_mv,
  input  wire logic [2*MV_W-1:0]    b_mv,
  input  wire logic [2*MV_W-1:0]    c_mv,
  output logic      [2*MV_W-1:0]    pred_mv
);
  initial
  begin
    if (MV_W < 2) $error("amc_skip_pred: vector width too small");
  end

  // Signed median of three components, except that p equal to q and above r gives r.
  function automatic logic [MV_W-1:0] med3(input logic [MV_W-1:0] p, q, r);
    logic signed [MV_W-1:0] a;
    logic signed [MV_W-1:0] b;
    logic signed [MV_W-1:0] c;
    a = p;
    b = q;
    c = r;
    if ((a >= b) == (a <= c)) return p;
    if ((b >= a) == (b <= c)) return q;
    return r;
  endfunction

  logic                 a_hit;
  logic                 b_hit;
  logic                 c_hit;
  logic [2*MV_W-1:0]    a_use;
  logic [2*MV_W-1:0]    b_use;
  logic [2*MV_W-1:0]    c_use;

  // Unavailable neighbours count as zero vectors with no matching reference.
  // RQ18 reference taken zero
  always_comb
  begin
    a_hit = a_avail && (a_ref == AMC_SKIP_REF);
    b_hit = b_avail && (b_ref == AMC_SKIP_REF);
    c_hit = c_avail && (c_ref == AMC_SKIP_REF);
    a_use = a_avail ? a_mv : '0;
    b_use = b_avail ? b_mv : '0;
    c_use = c_avail ? c_mv : '0;
  end

  // RQ19 zero predictor cases
  always_comb
  begin
    if (!a_avail || !b_avail || (a_hit && a_use == '0) || (b_hit && b_use == '0))
      pred_mv = '0;
    else if (a_hit && !b_hit && !c_hit)
      pred_mv = a_use;
    else if (!a_hit && b_hit && !c_hit)
      pred_mv = b_use;
    else if (!a_hit && !b_hit && c_hit)
      pred_mv = c_use;
    else
      pred_mv = {med3(a_use[2*MV_W-1:MV_W], b_use[2*MV_W-1:MV_W], c_use[2*MV_W-1:MV_W]),
                 med3(a_use[MV_W-1:0], b_use[MV_W-1:0], c_use[MV_W-1:0])};
  end
endmodule

//--- hdl/amc_cmd_end.sv
// Command-stream end: builds macroblock descriptors including skip and direct variants.
`timescale 1ns/10ps
module amc_cmd_end
  import amc_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         req_valid,
  input  wire logic         req_slice_b,
  input  wire amc_req_t     req_kind,
  input  wire logic [4:0]   req_kind_code,
  input  wire logic         req_inference_8x8,
  input  wire logic         req_transform_8x8,
  input  wire logic [7:0]   req_shape,
  input  wire logic [7:0]   req_pred_dir,
  input  wire logic [5:0]   req_vector_count,
  input  wire logic [15:0]  req_cbp_luma,
  input  wire logic [3:0]   req_cbp_cb,
  input  wire logic [3:0]   req_cbp_cr,
  input  wire logic         req_skip_conv_off,
  input  wire logic [15:0]  req_ref_idx,
  input  wire logic [31:0]  req_mv,
  amc_link_if.cmd           link
);
  logic         v_reg, v_next;
  logic         b_reg, b_next;
  logic [4:0]   kind_reg, kind_next;
  logic         skip_reg, skip_next;
  logic [3:0]   dmask_reg, dmask_next;
  logic [7:0]   shape_reg, shape_next;
  logic [7:0]   dir_reg, dir_next;
  logic [5:0]   cnt_reg, cnt_next;
  logic         t8_reg, t8_next;
  logic [23:0]  cbp_reg, cbp_next;
  logic         off_reg, off_next;
  logic [15:0]  ref_reg, ref_next;
  logic [31:0]  mv_reg, mv_next;

  // ---------------------------------------------------------------
  // Descriptor encoding
  // ---------------------------------------------------------------
  // RQ20 decision fields carried
  always_comb
  begin
    v_next = req_valid;
    b_next = req_slice_b;
    kind_next = req_kind_code;
    skip_next = 1'b0;
    dmask_next = 4'h0;
    shape_next = req_shape;
    dir_next = req_pred_dir;
    cnt_next = req_vector_count;
    t8_next = req_transform_8x8;
    cbp_next = {req_cbp_luma, req_cbp_cb, req_cbp_cr};
    off_next = req_skip_conv_off;
    ref_next = req_ref_idx;
    mv_next = req_mv;
    case (req_kind)
      AMC_REQ_SKIP:
      begin
        skip_next = 1'b1;
        cnt_next = 6'h00;
        if (!req_slice_b)
        begin
          // RQ1 P skip descriptor
          kind_next = AMC_KIND_L0_16X16;
        end
        else
        begin
          // RQ2 RQ3 B skip descriptor
          kind_next = AMC_KIND_8X8;
          dmask_next = AMC_DIRECT_ALL;
          shape_next = req_inference_8x8 ? AMC_SHAPE_4PAIR : AMC_SHAPE_16PAIR;
          t8_next = req_inference_8x8 && req_transform_8x8;
        end
      end
      AMC_REQ_DIRECT:
      begin
        // RQ4 RQ5 RQ6 direct variants
        kind_next = AMC_KIND_8X8;
        dmask_next = AMC_DIRECT_ALL;
        cnt_next = 6'h00;
        shape_next = req_inference_8x8 ? AMC_SHAPE_4PAIR : AMC_SHAPE_16PAIR;
        t8_next = req_inference_8x8 && req_transform_8x8;
      end
      default:
      begin
        skip_next = 1'b0;
      end
    endcase
  end

  // Registered so the link sees clean values; the packer accepts one per cycle.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      v_reg <= 1'b0;
      b_reg <= 1'b0;
      kind_reg <= AMC_KIND_RESERVED;
      skip_reg <= 1'b0;
      dmask_reg <= 4'h0;
      shape_reg <= 8'h00;
      dir_reg <= 8'h00;
      cnt_reg <= 6'h00;
      t8_reg <= 1'b0;
      cbp_reg <= 24'h000000;
      off_reg <= 1'b0;
      ref_reg <= 16'h0000;
      mv_reg <= 32'h00000000;
    end
    else
    begin
      v_reg <= v_next;
      b_reg <= b_next;
      kind_reg <= kind_next;
      skip_reg <= skip_next;
      dmask_reg <= dmask_next;
      shape_reg <= shape_next;
      dir_reg <= dir_next;
      cnt_reg <= cnt_next;
      t8_reg <= t8_next;
      cbp_reg <= cbp_next;
      off_reg <= off_next;
      ref_reg <= ref_next;
      mv_reg <= mv_next;
    end
  end

  assign link.mb_valid = v_reg;
  assign link.slice_is_b = b_reg;
  assign link.mb_kind_code = kind_reg;
  assign link.skip_indicator = skip_reg;
  assign link.direct_quadrant_mask = dmask_reg;
  assign link.sub_partition_shape = shape_reg;
  assign link.sub_prediction_direction = dir_reg;
  assign link.vector_count = cnt_reg;
  assign link.transform_8x8_flag = t8_reg;
  assign link.cbp_luma = cbp_reg[23:8];
  assign link.cbp_cb = cbp_reg[7:4];
  assign link.cbp_cr = cbp_reg[3:0];
  assign link.per_block_skip_conversion_off = off_reg;
  assign link.ref_idx_l0 = ref_reg;
  assign link.mv_x = mv_reg[15:0];
  assign link.mv_y = mv_reg[31:16];
endmodule

//--- hdl/amc_pak_end.sv
// Packer end: decides skip, direct and coded macroblock type for each descriptor.
`timescale 1ns/10ps
module amc_pak_end
  import amc_pkg::*;
#(
  parameter int MV_W = AMC_MV_W
)(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  amc_link_if.pak                   link,
  input  wire logic                 direct_conversion_off,
  input  wire logic                 skip_conversion_off,
  input  wire logic                 mbaff_mode,
  input  wire logic                 pair_skip_in,
  input  wire logic [4:0]           num_ref_active,
  input  wire logic [15:0]          quant_nz_luma,
  input  wire logic [3:0]           quant_nz_cb,
  input  wire logic [3:0]           quant_nz_cr,
  input  wire logic                 nb_a_avail,
  input  wire logic                 nb_b_avail,
  input  wire logic                 nb_c_avail,
  input  wire logic [AMC_REF_W-1:0] nb_a_ref,
  input  wire logic [AMC_REF_W-1:0] nb_b_ref,
  input  wire logic [AMC_REF_W-1:0] nb_c_ref,
  input  wire logic [2*MV_W-1:0]    nb_a_mv,
  input  wire logic [2*MV_W-1:0]    nb_b_mv,
  input  wire logic [2*MV_W-1:0]    nb_c_mv,
  output logic                      out_valid,
  output logic                      out_skip_flag,
  output logic [4:0]                out_mb_type,
  output logic [15:0]               out_cbp_luma,
  output logic [3:0]                out_cbp_cb,
  output logic [3:0]                out_cbp_cr,
  output logic                      out_vectors_coded,
  output logic                      out_ref_idx_coded,
  output logic                      out_pair_skip_permitted
);
  initial
  begin
    if (MV_W != AMC_MV_W) $error("amc_pak_end: vector width must match link");
  end

  logic [2*MV_W-1:0]  pred_mv;
  logic               pair_ok;
  logic [23:0]        cbp_q;
  logic               cbp_zero;
  logic               mv_eq;
  logic               is_8x8;
  logic               all_direct;
  logic               all_ref0;

  logic               v_reg, v_next;
  logic               skip_reg, skip_next;
  logic [4:0]         type_reg, type_next;
  logic [23:0]        cbp_reg, cbp_next;
  logic               mvc_reg, mvc_next;
  logic               refc_reg, refc_next;
  logic               pair_reg, pair_next;

  amc_skip_pred #(
    .MV_W (MV_W)
  ) u_pred (
    .a_avail (nb_a_avail),
    .b_avail (nb_b_avail),
    .c_avail (nb_c_avail),
    .a_ref   (nb_a_ref),
    .b_ref   (nb_b_ref),
    .c_ref   (nb_c_ref),
    .a_mv    (nb_a_mv),
    .b_mv    (nb_b_mv),
    .c_mv    (nb_c_mv),
    .pred_mv (pred_mv)
  );

  // ---------------------------------------------------------------
  // Decision terms
  // ---------------------------------------------------------------
  always_comb
  begin
    // RQ21 pair skip outside MBAFF
    pair_ok = mbaff_mode ? pair_skip_in : 1'b1;
    // RQ10 post-quantization CBP
    cbp_q = {link.cbp_luma & quant_nz_luma, link.cbp_cb & quant_nz_cb,
             link.cbp_cr & quant_nz_cr};
    cbp_zero = (cbp_q == 24'h000000);
    // RQ18 compare at reference zero
    mv_eq = ({link.mv_y, link.mv_x} == pred_mv) && (link.ref_idx_l0[3:0] == AMC_SKIP_REF);
    is_8x8 = (link.mb_kind_code == AMC_KIND_8X8);
    all_direct = (link.direct_quadrant_mask == AMC_DIRECT_ALL);
    // RQ7 detect all-zero references
    all_ref0 = (link.ref_idx_l0 == 16'h0000) && (num_ref_active > 5'h01);
  end

  // ---------------------------------------------------------------
  // Conversion decision
  // ---------------------------------------------------------------
  // Everything is decided in one cycle, so no back-pressure is needed on the link.
  always_comb
  begin
    v_next = link.mb_valid;
    skip_next = 1'b0;
    type_next = AMC_P_TYPE_L0_16X16;
    cbp_next = cbp_q;
    mvc_next = 1'b1;
    refc_next = 1'b0;
    pair_next = pair_ok;
    if (!link.slice_is_b)
    begin
      // RQ9 P slice conversions
      if (link.skip_indicator)
      begin
        // RQ11 RQ12 forced P skip
        cbp_next = 24'h000000;
        skip_next = pair_ok;
        type_next = AMC_P_TYPE_L0_16X16;
      end
      else if (link.mb_kind_code == AMC_KIND_L0_16X16)
      begin
        // RQ8 RQ13 RQ14 RQ15 skip conversion
        skip_next = !skip_conversion_off && !link.per_block_skip_conversion_off &&
                    cbp_zero && mv_eq && pair_ok;
        type_next = AMC_P_TYPE_L0_16X16;
        refc_next = (num_ref_active > 5'h01);
      end
      else
      begin
        refc_next = (num_ref_active > 5'h01);
        case (link.mb_kind_code)
          AMC_KIND_L0_L0_16X8: type_next = AMC_P_TYPE_16X8;
          AMC_KIND_L0_L0_8X16: type_next = AMC_P_TYPE_8X16;
          AMC_KIND_8X8:
          begin
            // RQ7 choose reference-zero packing
            type_next = all_ref0 ? AMC_P_TYPE_8X8_REF0 : AMC_P_TYPE_8X8;
            refc_next = (num_ref_active > 5'h01) && !all_ref0;
          end
          default: type_next = AMC_P_TYPE_L0_16X16;
        endcase
      end
    end
    else
    begin
      // RQ16 no predictor check in B
      if (link.skip_indicator)
      begin
        cbp_next = 24'h000000;
        skip_next = pair_ok;
        type_next = AMC_B_TYPE_DIRECT;
        mvc_next = 1'b0;
      end
      else if (is_8x8 && all_direct && !direct_conversion_off)
      begin
        // RQ8 slice and block disables
        skip_next = !skip_conversion_off && !link.per_block_skip_conversion_off &&
                    cbp_zero && pair_ok;
        type_next = AMC_B_TYPE_DIRECT;
        mvc_next = 1'b0;
      end
      else
      begin
        type_next = link.mb_kind_code;
        mvc_next = (link.direct_quadrant_mask != AMC_DIRECT_ALL);
      end
    end
    // RQ17 skip carries nothing else
    if (skip_next)
    begin
      cbp_next = 24'h000000;
      mvc_next = 1'b0;
      refc_next = 1'b0;
    end
    if (!link.mb_valid)
    begin
      skip_next = 1'b0;
      mvc_next = 1'b0;
      refc_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      v_reg <= 1'b0;
      skip_reg <= 1'b0;
      type_reg <= AMC_P_TYPE_L0_16X16;
      cbp_reg <= 24'h000000;
      mvc_reg <= 1'b0;
      refc_reg <= 1'b0;
      pair_reg <= 1'b1;
    end
    else
    begin
      v_reg <= v_next;
      skip_reg <= skip_next;
      type_reg <= type_next;
      cbp_reg <= cbp_next;
      mvc_reg <= mvc_next;
      refc_reg <= refc_next;
      pair_reg <= pair_next;
    end
  end

  assign out_valid = v_reg;
  assign out_skip_flag = skip_reg;
  assign out_mb_type = type_reg;
  assign out_cbp_luma = cbp_reg[23:8];
  assign out_cbp_cb = cbp_reg[7:4];
  assign out_cbp_cr = cbp_reg[3:0];
  assign out_vectors_coded = mvc_reg;
  assign out_ref_idx_coded = refc_reg;
  assign out_pair_skip_permitted = pair_reg;
endmodule

//--- tb/amc_monitor.sv
// Concurrent checks on the descriptor link between the command end and the packer end.
`timescale 1ns/10ps
module amc_monitor
  import amc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       mb_valid,
  input  wire logic       slice_is_b,
  input  wire logic [4:0] mb_kind_code,
  input  wire logic       skip_indicator,
  input  wire logic [3:0] direct_quadrant_mask,
  input  wire logic [7:0] sub_partition_shape,
  input  wire logic [5:0] vector_count,
  input  wire logic       transform_8x8_flag
);
  // ------------------------
  // Descriptor classes
  // ------------------------
  // One clock domain, so clocking and reset qualification are given once.
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Skip and direct descriptors as they appear on the link.
  sequence s_pskip;
    mb_valid && !slice_is_b && skip_indicator;
  endsequence
  sequence s_bskip;
    mb_valid && slice_is_b && skip_indicator;
  endsequence
  sequence s_bdirect;
    mb_valid && slice_is_b && !skip_indicator && direct_quadrant_mask == AMC_DIRECT_ALL;
  endsequence

  // ------------------------
  // Encoding checks
  // ------------------------
  // Skip and direct carry no vectors, because the packer infers them instead.
  a_pskip_code: assert property (s_pskip |-> mb_kind_code == AMC_KIND_L0_16X16)
    else $error("P skip descriptor carries the wrong kind code");
  a_skip_novec: assert property (mb_valid && skip_indicator |-> vector_count == 6'h00)
    else $error("Skip descriptor carries coded vectors");
  a_bskip_kind: assert property (s_bskip |-> {mb_kind_code, direct_quadrant_mask} == 9'h16F)
    else $error("B skip descriptor has wrong kind code or direct mask");
  a_bskip_shape: assert property (s_bskip |-> sub_partition_shape inside {8'h00, 8'hFF})
    else $error("B skip descriptor has an illegal sub-partition shape");
  a_fine_no_t8: assert property (mb_valid && direct_quadrant_mask == AMC_DIRECT_ALL &&
    sub_partition_shape == AMC_SHAPE_16PAIR |-> !transform_8x8_flag)
    else $error("Sixteen-pair variant keeps the 8x8 transform flag set");
  a_direct_kind: assert property (s_bdirect |-> mb_kind_code == AMC_KIND_8X8)
    else $error("B direct descriptor has the wrong kind code");
  a_direct_novec: assert property (s_bdirect |-> vector_count == 6'h00)
    else $error("B direct descriptor carries coded vectors");
  // A descriptor can never be on the link in the first cycle after reset.
  a_reset_idle: assert property ($fell(rst) |-> !mb_valid)
    else $error("Descriptor valid straight after reset");
endmodule

//--- tb/test_avc_mb_type_skip_direct_conversion.sv
// Bench joining the command end and the packer end, with table-driven conversion cases.
`timescale 1ns/10ps
`define CHK(nm, e, g) compare(nm, 32'(e), 32'(g))
module test_avc_mb_type_skip_direct_conversion
  import amc_pkg::*;
();
  // ------------------------
  // Case table
  // ------------------------
  // Flag nibbles: {slice_b, infer_8x8, block_skip_off, slice_skip_off},
  // {direct_off, mbaff, pair_in, nb_avail}, {nb_zero, mv_is_nb, skip_expected, 0}.
  typedef struct packed {
    amc_req_t    k;
    logic [4:0]  code;
    logic [11:0] f;
    logic [15:0] cbp;
    logic [15:0] qnz;
    logic [15:0] refs;
    logic [4:0]  nref;
    logic [4:0]  et;
  } amc_row_t;
  localparam amc_req_t    SK    = AMC_REQ_SKIP;
  localparam amc_req_t    DI    = AMC_REQ_DIRECT;
  localparam amc_req_t    NO    = AMC_REQ_NORMAL;
  localparam logic [31:0] NB_MV = 32'h0002_0003;
  localparam int          NROWS = 25;
  amc_row_t rows [NROWS] = '{
    '{SK,5'h00,12'h002,16'hFFFF,16'hFFFF,16'h0000,5'h01,5'h00},
    '{SK,5'h00,12'h040,16'hFFFF,16'hFFFF,16'h0000,5'h01,5'h00},
    '{SK,5'h00,12'h302,16'hFFFF,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h002,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h062,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h040,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h100,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h200,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h000,16'h0001,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h002,16'hFFFF,16'h0000,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h004,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h016,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h01A,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h01,12'h000,16'h0000,16'hFFFF,16'h0001,5'h02,5'h00},
    '{NO,5'h04,12'h000,16'h0000,16'hFFFF,16'h0000,5'h01,5'h01},
    '{NO,5'h05,12'h000,16'h0000,16'hFFFF,16'h0000,5'h01,5'h02},
    '{NO,5'h16,12'h000,16'h0000,16'hFFFF,16'h1111,5'h02,5'h03},
    '{NO,5'h16,12'h000,16'h0000,16'hFFFF,16'h0000,5'h02,5'h04},
    '{SK,5'h00,12'hC02,16'hFFFF,16'hFFFF,16'h0000,5'h01,5'h00},
    '{SK,5'h00,12'h840,16'hFFFF,16'hFFFF,16'h0000,5'h01,5'h00},
    '{DI,5'h00,12'hC06,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{DI,5'h00,12'h800,16'h0001,16'hFFFF,16'h0000,5'h01,5'h00},
    '{DI,5'h00,12'h880,16'h0000,16'hFFFF,16'h0000,5'h01,5'h16},
    '{DI,5'h00,12'h900,16'h0000,16'hFFFF,16'h0000,5'h01,5'h00},
    '{NO,5'h03,12'h800,16'h0000,16'hFFFF,16'h0000,5'h01,5'h03}};

  amc_row_t    cur;
  logic        core_clk = 1'h0;
  logic        rst      = 1'h1;
  logic        req_valid;
  logic        out_valid, out_skip_flag, out_vectors_coded, out_pair_skip_permitted;
  logic        out_ref_idx_coded;
  logic [4:0]  out_mb_type;
  logic [15:0] out_cbp_luma;
  logic [3:0]  out_cbp_cb, out_cbp_cr;
  int          n_errors = 0;
  int          checks   = 0;
  // All three neighbours share one reference and vector, so the median equals it.
  wire logic [3:0]  nb_ref = cur.f[3] ? 4'h0 : 4'h1;
  wire logic [31:0] nb_mv  = cur.f[3] ? 32'h0000_0000 : NB_MV;

  // ------------------------
  // Ends under test
  // ------------------------
  amc_link_if link ();
  amc_cmd_end amc_cmd_end_i (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_slice_b(cur.f[11]),
    .req_kind(cur.k), .req_kind_code(cur.code), .req_inference_8x8(cur.f[10]),
    .req_transform_8x8(cur.f[11]), .req_shape(8'h00), .req_pred_dir(8'h00),
    .req_vector_count({5'h00, cur.k == NO}), .req_cbp_luma(cur.cbp),
    .req_cbp_cb(cur.cbp[3:0]), .req_cbp_cr(cur.cbp[7:4]), .req_skip_conv_off(cur.f[9]),
    .req_ref_idx(cur.refs), .req_mv(cur.f[2] ? NB_MV : 32'h0000_0000), .link(link));
  amc_pak_end amc_pak_end_i (
    .core_clk(core_clk), .rst(rst), .link(link), .direct_conversion_off(cur.f[7]),
    .skip_conversion_off(cur.f[8]), .mbaff_mode(cur.f[6]), .pair_skip_in(cur.f[5]),
    .num_ref_active(cur.nref), .quant_nz_luma(cur.qnz), .quant_nz_cb(cur.qnz[3:0]),
    .quant_nz_cr(cur.qnz[7:4]), .nb_a_avail(cur.f[4]), .nb_b_avail(cur.f[4]),
    .nb_c_avail(cur.f[4]), .nb_a_ref(nb_ref), .nb_b_ref(nb_ref), .nb_c_ref(nb_ref),
    .nb_a_mv(nb_mv), .nb_b_mv(nb_mv), .nb_c_mv(nb_mv), .out_valid(out_valid),
    .out_skip_flag(out_skip_flag), .out_mb_type(out_mb_type), .out_cbp_luma(out_cbp_luma),
    .out_cbp_cb(out_cbp_cb), .out_cbp_cr(out_cbp_cr), .out_vectors_coded(out_vectors_coded),
    .out_ref_idx_coded(out_ref_idx_coded), .out_pair_skip_permitted(out_pair_skip_permitted));
  amc_monitor amc_monitor_i (
    .core_clk(core_clk), .rst(rst), .mb_valid(link.mb_valid), .slice_is_b(link.slice_is_b),
    .mb_kind_code(link.mb_kind_code), .skip_indicator(link.skip_indicator),
    .direct_quadrant_mask(link.direct_quadrant_mask),
    .sub_partition_shape(link.sub_partition_shape), .vector_count(link.vector_count),
    .transform_8x8_flag(link.transform_8x8_flag));

  // ------------------------
  // Checking tasks
  // ------------------------
  // Case equality keeps an unknown output from passing as a match.
  task automatic compare(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The link shows the descriptor one cycle after the request.
  task automatic check_link;
    `CHK("link_valid", 1'h1, link.mb_valid);
    `CHK("link_cbp", cur.cbp, link.cbp_luma);
    `CHK("link_skip", cur.k == SK, link.skip_indicator);
    if (cur.k == SK) `CHK("link_count", 6'h00, link.vector_count);
    if (!cur.f[11] && cur.k == SK) `CHK("link_pkind", 5'h01, link.mb_kind_code);
    if (cur.f[11] && cur.k != NO)
    begin
      `CHK("link_kind", 9'h16F, {link.mb_kind_code, link.direct_quadrant_mask});
      `CHK("link_shape", cur.f[10] ? 8'h00 : 8'hFF, link.sub_partition_shape);
      if (!cur.f[10]) `CHK("link_t8", 1'h0, link.transform_8x8_flag);
      if (cur.k == DI) `CHK("link_dcount", 6'h00, link.vector_count);
    end
  endtask

  // A forced skip clears the coded pattern even when it must be coded after all.
  task automatic check_out;
    logic [15:0] ec;
    ec = (cur.f[1] || cur.k == SK) ? 16'h0000 : cur.cbp & cur.qnz;
    `CHK("out_valid", 1'h1, out_valid);
    `CHK("out_skip", cur.f[1], out_skip_flag);
    if (!cur.f[1]) `CHK("out_type", cur.et, out_mb_type);
    `CHK("out_cbp", {ec, ec[3:0], ec[7:4]}, {out_cbp_luma, out_cbp_cb, out_cbp_cr});
    if (cur.f[1]) `CHK("out_vectors", 1'h0, out_vectors_coded);
    `CHK("out_refs", cur.nref > 5'h01 && cur.refs != 16'h0000, out_ref_idx_coded);
    `CHK("out_pair", cur.f[6] ? cur.f[5] : 1'h1, out_pair_skip_permitted);
  endtask

  task automatic run_row(input int i);
    @(negedge core_clk);
    cur = rows[i];
    req_valid = 1'h1;
    @(negedge core_clk);
    req_valid = 1'h0;
    check_link();
    @(negedge core_clk);
    check_out();
  endtask

  // ------------------------
  // Sequence
  // ------------------------
  // Inputs change on the falling edge, well away from the sampling edge.
  always #20 core_clk = ~core_clk;

  initial
  begin
    cur = rows[0];
    req_valid = 1'h0;
    repeat (6) @(negedge core_clk);
    rst = 1'h0;
    for (int i = 0; i < NROWS; i++)
      run_row(i);
    // Back to back: a forced skip then a 16x8 block, with equal packer-side inputs.
    @(negedge core_clk);
    req_valid = 1'h1;
    cur = rows[0];
    @(negedge core_clk);
    cur = rows[14];
    @(negedge core_clk);
    req_valid = 1'h0;
    `CHK("b2b_skip", 2'h3, {out_valid, out_skip_flag});
    @(negedge core_clk);
    `CHK("b2b_type", 7'h41, {out_valid, out_skip_flag, out_mb_type});
    // Reset in mid-flight drops the descriptor and restores the idle outputs.
    @(negedge core_clk);
    cur = rows[1];
    req_valid = 1'h1;
    @(negedge core_clk);
    req_valid = 1'h0;
    rst = 1'h1;
    @(negedge core_clk);
    rst = 1'h0;
    `CHK("rst_state", 3'h1, {link.mb_valid, out_valid, out_pair_skip_permitted});
    @(negedge core_clk);
    `CHK("rst_drop", 1'h0, out_valid);
    report_and_stop();
  end

  // About 90 cycles are needed; the margin covers any stall without hiding a hang.
  initial
  begin
    repeat (2000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end
endmodule
